// file: inc/etc_pkg.sv
// Purpose: Shared constants for the external trigger conditioning block
// Assumes: 32-bit APB register bus, one timer kernel clock
// Notes:   Filter code tables are held here as functions
package etc_pkg;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;

    // Control register field positions
    localparam int MODE1_EN_BIT   = 0;
    localparam int TRIG_SRC_LSB   = 4;
    localparam int FILT_SEL_LSB   = 8;
    localparam int PRESC_SEL_LSB  = 12;
    localparam int MODE2_EN_BIT   = 14;
    localparam int POLARITY_BIT   = 15;

    // Status register field positions
    localparam int ST_FILTERED_BIT  = 0;
    localparam int ST_PRESCALED_BIT = 1;
    localparam int ST_SLAVE_TRG_BIT = 2;

    // Reset value of the control register
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Codes
    localparam logic [3:0] FILT_OFF      = 4'h0;
    localparam logic [2:0] TRIG_SRC_FILT = 3'h7;
    localparam logic [1:0] PRESC_DIV1    = 2'h0;
    localparam logic [1:0] PRESC_DIV2    = 2'h1;
    localparam logic [1:0] PRESC_DIV4    = 2'h2;

    // Sampling divider minus one for each filter code
    function automatic logic [4:0] etc_filt_div_m1(input logic [3:0] code);
        case (code)
            4'h4, 4'h5:       etc_filt_div_m1 = 5'h01;
            4'h6, 4'h7:       etc_filt_div_m1 = 5'h03;
            4'h8, 4'h9:       etc_filt_div_m1 = 5'h07;
            4'ha, 4'hb, 4'hc: etc_filt_div_m1 = 5'h0f;
            4'hd, 4'he, 4'hf: etc_filt_div_m1 = 5'h1f;
            default:          etc_filt_div_m1 = 5'h00;
        endcase
    endfunction

    // Filter length minus one for each filter code
    function automatic logic [2:0] etc_filt_len_m1(input logic [3:0] code);
        case (code)
            4'h1:             etc_filt_len_m1 = 3'h1;
            4'h2:             etc_filt_len_m1 = 3'h3;
            4'h4, 4'h6, 4'h8,
            4'hb, 4'he:       etc_filt_len_m1 = 3'h5;
            4'ha, 4'hd:       etc_filt_len_m1 = 3'h4;
            4'h0:             etc_filt_len_m1 = 3'h0;
            default:          etc_filt_len_m1 = 3'h7;
        endcase
    endfunction

    // Index into the master trigger bus (bit k is timer k+1) per slave timer and input
    function automatic logic [2:0] etc_master_idx(input int slave, input logic [1:0] itr);
        logic [11:0] map;
        map = 12'h000;
        case (slave)
            3:       map = {3'h3, 3'h4, 3'h1, 3'h0};
            4:       map = {3'h7, 3'h2, 3'h1, 3'h0};
            5:       map = {3'h7, 3'h3, 3'h2, 3'h1};
            default: map = {3'h3, 3'h2, 3'h7, 3'h0};
        endcase
        etc_master_idx = map[itr*3 +: 3];
    endfunction

endpackage

// file: src/etc_filter.sv
// Purpose: Digital sampling filter for the prescaled external trigger
// Assumes: Input synchronous to i_clk; dead-time sampling clock equals i_clk
// Notes:   A change of filter code restarts the sampling divider
`timescale 1ns/100ps
`default_nettype none
module etc_filter (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic [3:0] i_filter_sel,
    input  wire logic       i_din,
    output logic            o_dout
);
    logic [3:0] code_q;
    logic [4:0] div_cnt;
    logic [4:0] div_m1;
    logic [2:0] len_m1;
    logic [2:0] run_cnt;
    logic       sample_en;

    assign div_m1 = etc_pkg::etc_filt_div_m1(i_filter_sel);
    assign len_m1 = etc_pkg::etc_filt_len_m1(i_filter_sel);

    // Sampling divider, restarted on a code change so no short gap is seen
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            div_cnt <= 5'h00;
            code_q  <= 4'h0;
        end else begin
            code_q <= i_filter_sel;
            if (code_q != i_filter_sel || div_cnt == div_m1) begin
                div_cnt <= 5'h00;
            end else begin
                div_cnt <= div_cnt + 5'h01;
            end
        end
    end
    assign sample_en = (div_cnt == div_m1) && (code_q == i_filter_sel); // see RULE1

    // Count consecutive samples that disagree with the output
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_dout  <= 1'b0;
            run_cnt <= 3'h0;
        end else if (i_filter_sel == etc_pkg::FILT_OFF) begin
            o_dout  <= i_din;                  // see RULE10
            run_cnt <= 3'h0;
        end else if (sample_en) begin
            if (i_din == o_dout) begin
                run_cnt <= 3'h0;               // Agreeing sample breaks the run
            end else if (run_cnt == len_m1) begin
                o_dout  <= i_din;              // see RULE2
                run_cnt <= 3'h0;
            end else begin
                run_cnt <= run_cnt + 3'h1;
            end
        end
    end

    // Helper: cycles since the previous sample strobe
    logic [5:0] gap;
    logic       gap_valid;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            gap       <= 6'h00;
            gap_valid <= 1'b0;
        end else if (sample_en || code_q != i_filter_sel) begin
            gap       <= 6'h00;
            gap_valid <= sample_en;
        end else begin
            gap <= gap + 6'h01;
        end
    end

    AST_SAMPLE_SPACING: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE1
        (sample_en && gap_valid && i_filter_sel != etc_pkg::FILT_OFF) |-> (gap == {1'b0, div_m1}))
        else $error("Filter sample spacing does not match divider");
    AST_FILTER_RUN: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE2
        ($changed(o_dout) && $stable(i_filter_sel) && i_filter_sel != etc_pkg::FILT_OFF)
        |-> ($past(sample_en) && $past(run_cnt) == len_m1 && $past(i_din) == o_dout))
        else $error("Filter output changed without a full run of samples");
    AST_FILTER_OFF: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE10
        (i_filter_sel == etc_pkg::FILT_OFF && $past(i_filter_sel) == etc_pkg::FILT_OFF) |-> o_dout == $past(i_din))
        else $error("Disabled filter does not follow its input");
    CVR_LONG_FILTER: cover property (@(posedge i_clk) disable iff (i_reset)
        i_filter_sel == 4'hf && $changed(o_dout));

endmodule // etc_filter
`default_nettype wire

// file: src/etc_top.sv
// Purpose: External trigger conditioning and trigger source selection for a timer
// Assumes: APB slave with zero wait states; all inputs synchronous to i_clk
// Notes:   Counter and slave mode controller sit outside; o_count_tick drives the counter
//
// Summary of operation
// RULE1: Filter samples at kernel clock over DIV; codes 1010-1111 give DIV 16/32.
// RULE2: Filter output flips only after N consecutive samples agree on the new level.
// RULE3: Prescaler field 13:12 divides trigger by 1, 2, 4 or 8.
// RULE4: Software keeps the prescaled trigger at most a quarter of kernel clock.
// RULE5: Clock mode 2 enable bit 14 clocks the counter from the filtered trigger.
// RULE6: Software must not pick filtered trigger as slave input when mode 2 is on.
// RULE7: With clock modes 1 and 2 both on, count from the filtered trigger.
// RULE8: Polarity bit 15 clear keeps trigger uninverted; set inverts it.
// RULE9: Source codes 000-011 select internal triggers 0-3 wired to fixed master timers.
// RULE10: Filter code 0000 disables filtering; trigger simply sampled each clock.
// RULE11: Stages run in order polarity, prescaler, filter; filter output feeds selection.
`timescale 1ns/100ps
`default_nettype none
module etc_top #(
    parameter int SLAVE_TIMER = 2,
    parameter int ADDR_W      = 12
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    input  wire logic              i_ext_trigger_in,
    input  wire logic [7:0]        i_master_trigger,
    input  wire logic [2:0]        i_channel_trigger,
    output logic                   o_ext_trigger_prescaled,
    output logic                   o_ext_trigger_filtered,
    output logic                   o_slave_trigger_input,
    output logic                   o_count_tick
);
    logic [31:0] ctrl;
    logic        mode1_en;
    logic [2:0]  trigger_source_sel;
    logic [3:0]  ext_trig_filter_sel;
    logic [1:0]  ext_trig_prescale_sel;
    logic        ext_clock_mode2_en;
    logic        ext_trig_polarity;
    logic        addr_hit;
    logic        pol_q;
    logic        pol_d;
    logic        pol_rise;
    logic [2:0]  edge_cnt;
    logic        next_slave_trigger;
    logic        clk_src;
    logic        clk_src_d;
    logic [3:0]  internal_trigger;

    // Control fields
    assign mode1_en              = ctrl[etc_pkg::MODE1_EN_BIT];
    assign trigger_source_sel    = ctrl[etc_pkg::TRIG_SRC_LSB +: 3];
    assign ext_trig_filter_sel   = ctrl[etc_pkg::FILT_SEL_LSB +: 4];
    assign ext_trig_prescale_sel = ctrl[etc_pkg::PRESC_SEL_LSB +: 2];
    assign ext_clock_mode2_en    = ctrl[etc_pkg::MODE2_EN_BIT];
    assign ext_trig_polarity     = ctrl[etc_pkg::POLARITY_BIT];

    // APB decode; only two words are mapped
    always_comb begin
        if (i_paddr[11:0] == etc_pkg::CTRL_OFFSET) begin
            addr_hit = 1'b1;
        end else if (i_paddr[11:0] == etc_pkg::STATUS_OFFSET) begin
            addr_hit = 1'b1;
        end else begin
            addr_hit = 1'b0;
        end
    end
    assign o_pready  = i_psel & i_penable;
    assign o_pslverr = o_pready & ~addr_hit;  // Unmapped words answer with an error

    // Control register write, taken at the access edge; reserved bits dropped
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl <= etc_pkg::CTRL_RESET;
        end else if (o_pready && i_pwrite && i_paddr[11:0] == etc_pkg::CTRL_OFFSET) begin
            ctrl <= i_pwdata & 32'h0000_ff71;  // Bit 7 belongs to the slave controller, not here
        end
    end

    // Read data latched in the setup cycle so the data output comes from a flop
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            if (i_paddr[11:0] == etc_pkg::CTRL_OFFSET) begin
                o_prdata <= ctrl;
            end else if (i_paddr[11:0] == etc_pkg::STATUS_OFFSET) begin
                o_prdata <= {29'h0, o_slave_trigger_input, o_ext_trigger_prescaled, o_ext_trigger_filtered};
            end else begin
                o_prdata <= 32'h0000_0000;
            end
        end
    end

    // Polarity stage, first in the chain
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pol_q <= 1'b0;
            pol_d <= 1'b0;
        end else begin
            pol_q <= i_ext_trigger_in ^ ext_trig_polarity;  // see RULE8 RULE11
            pol_d <= pol_q;
        end
    end
    assign pol_rise = pol_q & ~pol_d;

    // Prescaler: an edge counter bit toggles once per 1, 2 or 4 active edges, giving one output period per 2, 4 or 8 edges.
    // Software must keep its output slow enough for the filter to see every level.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            edge_cnt                <= 3'h0;
            o_ext_trigger_prescaled <= 1'b0;
        end else begin
            edge_cnt <= edge_cnt + {2'h0, pol_rise};
            case (ext_trig_prescale_sel)  // see RULE3 RULE4
                etc_pkg::PRESC_DIV1: o_ext_trigger_prescaled <= pol_q;
                etc_pkg::PRESC_DIV2: o_ext_trigger_prescaled <= edge_cnt[0];
                etc_pkg::PRESC_DIV4: o_ext_trigger_prescaled <= edge_cnt[1];
                default:             o_ext_trigger_prescaled <= edge_cnt[2];
            endcase
        end
    end

    // Sampling filter, last stage before selection
    etc_filter u_filter (
        .i_clk        (i_clk),
        .i_reset      (i_reset),
        .i_filter_sel (ext_trig_filter_sel),
        .i_din        (o_ext_trigger_prescaled),  // see RULE11
        .o_dout       (o_ext_trigger_filtered)
    );

    // Internal trigger wiring from fixed master timers
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_itr
            assign internal_trigger[g] = i_master_trigger[etc_pkg::etc_master_idx(SLAVE_TIMER, 2'(g))];
        end
    endgenerate

    // Slave trigger selection
    always_comb begin
        case (trigger_source_sel)
            3'h0, 3'h1, 3'h2, 3'h3: next_slave_trigger = internal_trigger[trigger_source_sel[1:0]]; // see RULE9
            3'h4:    next_slave_trigger = i_channel_trigger[0];
            3'h5:    next_slave_trigger = i_channel_trigger[1];
            3'h6:    next_slave_trigger = i_channel_trigger[2];
            default: next_slave_trigger = o_ext_trigger_filtered;
        endcase
    end

    // Counting clock source; mode 2 wins over mode 1
    assign clk_src = ext_clock_mode2_en ? o_ext_trigger_filtered  // see RULE5 RULE7
                   : (mode1_en & o_slave_trigger_input);
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_slave_trigger_input <= 1'b0;
            clk_src_d             <= 1'b0;
            o_count_tick          <= 1'b0;
        end else begin
            o_slave_trigger_input <= next_slave_trigger;
            clk_src_d             <= clk_src;
            o_count_tick          <= (ext_clock_mode2_en | mode1_en) & clk_src & ~clk_src_d; // see RULE5
        end
    end

    AST_POLARITY: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE8
        $stable(ext_trig_polarity) |-> pol_d == $past(i_ext_trigger_in ^ ext_trig_polarity, 2))
        else $error("Polarity stage does not follow input and polarity bit");
    AST_PRESC_PASS: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE3
        (ext_trig_prescale_sel == etc_pkg::PRESC_DIV1 && $stable(ext_trig_prescale_sel))
        |-> o_ext_trigger_prescaled == $past(pol_q))
        else $error("Undivided prescaler does not pass the trigger");
    AST_PRESC_DIV2: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE3
        (ext_trig_prescale_sel == etc_pkg::PRESC_DIV2 && $past(ext_trig_prescale_sel) == etc_pkg::PRESC_DIV2
         && $past(ext_trig_prescale_sel, 2) == etc_pkg::PRESC_DIV2 && $changed(o_ext_trigger_prescaled))
        |-> $past(pol_rise, 2))
        else $error("Divide-by-two output changed without an input edge");
    AST_MODE2_TICK: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE5
        (ext_clock_mode2_en && $rose(o_ext_trigger_filtered)) |=> o_count_tick)
        else $error("Filtered trigger edge did not clock the counter");
    AST_MODE12_SRC: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE7
        (o_count_tick && $past(ext_clock_mode2_en) && $past(mode1_en))
        |-> $past(o_ext_trigger_filtered) && !$past(clk_src_d))
        else $error("Counting clock not taken from the filtered trigger");
    AST_ITR_SELECT: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE9
        ($past(trigger_source_sel) == 3'h1) |-> o_slave_trigger_input == $past(internal_trigger[1]))
        else $error("Internal trigger 1 not routed to slave input");
    AST_CHAIN_ORDER: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE11
        (ext_trig_filter_sel == etc_pkg::FILT_OFF && $past(ext_trig_filter_sel) == etc_pkg::FILT_OFF)
        |-> o_ext_trigger_filtered == $past(o_ext_trigger_prescaled))
        else $error("Filter is not fed from the prescaler");
    AST_NO_TICK_IDLE: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE5
        ($past(!ext_clock_mode2_en && !mode1_en)) |-> !o_count_tick)
        else $error("Counter ticked with no external clock mode");

    CVR_MODE2_COUNT: cover property (@(posedge i_clk) disable iff (i_reset) ext_clock_mode2_en && o_count_tick);
    CVR_DIV8: cover property (@(posedge i_clk) disable iff (i_reset)
        ext_trig_prescale_sel == 2'h3 && $rose(o_ext_trigger_prescaled));
    CVR_INVERTED: cover property (@(posedge i_clk) disable iff (i_reset)
        ext_trig_polarity && $rose(o_ext_trigger_filtered));

endmodule // etc_top
`default_nettype wire

// file: dv/etc_trigger_source.sv
// Purpose: Far-side model driving the external trigger pin and the master timer triggers
// Assumes: Driven by the bench through tasks; every change lands just after a rising edge
// Notes:   Channel triggers stand in for the capture channels that sit outside
`timescale 1ns/100ps
`default_nettype none
module etc_trigger_source (
    input  wire logic       i_clk,
    output var  logic       o_ext_trigger_in,
    output var  logic [7:0] o_master_trigger,
    output var  logic [2:0] o_channel_trigger
);
    // Idle levels from time zero
    initial begin
        o_ext_trigger_in  = 1'b0;
        o_master_trigger  = 8'h00;
        o_channel_trigger = 3'h0;
    end

    // Pin level change at the next edge
    task automatic set_pin(input logic v);
        @(posedge i_clk);
        o_ext_trigger_in <= v;
    endtask

    // Square wave; the half period is clamped so an undivided trigger never beats clk/4
    task automatic toggle(input int half, input int periods);
        int h;
        h = (half < 2) ? 2 : half;
        repeat (periods) begin
            set_pin(1'b1);
            repeat (h - 1) @(posedge i_clk);
            set_pin(1'b0);
            repeat (h - 1) @(posedge i_clk);
        end
    endtask

    // One pulse of w cycles on a master trigger line
    task automatic pulse_master(input int b, input int w);
        @(posedge i_clk);
        o_master_trigger[b] <= 1'b1;
        repeat (w) @(posedge i_clk);
        o_master_trigger[b] <= 1'b0;
    endtask

    // One pulse of w cycles on a channel trigger line
    task automatic pulse_channel(input int b, input int w);
        @(posedge i_clk);
        o_channel_trigger[b] <= 1'b1;
        repeat (w) @(posedge i_clk);
        o_channel_trigger[b] <= 1'b0;
    endtask
endmodule // etc_trigger_source
`default_nettype wire

// file: dv/test_timer_ext_trigger_conditioning.sv
// Purpose: Self-checking bench for the external trigger conditioning block
// Assumes: Zero-wait APB slave; filter sampling clock equals the kernel clock
// Notes:   Read data is checked from a queue of expected words by a separate monitor
`timescale 1ns/100ps
`default_nettype none
module test_timer_ext_trigger_conditioning;
    logic        i_clk;
    logic        i_reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_pin;
    logic [7:0]  mtrig;
    logic [2:0]  ctrig;
    logic        ext_prescaled;
    logic        ext_filtered;
    logic        slave_trig;
    logic        tick;
    int          mismatches;
    int          checked;
    int          ticks;
    logic [31:0] exp_q[$];
    int          n_tab[16]   = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
    int          div_tab[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
    int          map_tab[4]  = '{0, 7, 2, 3};

    etc_top #(.SLAVE_TIMER(2), .ADDR_W(12)) dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_ext_trigger_in(ext_pin), .i_master_trigger(mtrig), .i_channel_trigger(ctrig),
        .o_ext_trigger_prescaled(ext_prescaled), .o_ext_trigger_filtered(ext_filtered),
        .o_slave_trigger_input(slave_trig), .o_count_tick(tick));

    etc_trigger_source pm (.i_clk(i_clk), .o_ext_trigger_in(ext_pin), .o_master_trigger(mtrig),
                           .o_channel_trigger(ctrig));

    // Free-running 100 MHz clock
    always #5 i_clk = ~i_clk;

    task automatic complete_run();
        $display("Counts: checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic err);
        int n;
        @(posedge i_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check({31'h0, pready}, 32'h1);
        check({31'h0, pslverr}, {31'h0, err});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        exp_q.push_back(exp);
        apb(1'b0, a, 32'h0000_0000, err);
    endtask

    task automatic wr_ctrl(input logic [31:0] v);
        apb(1'b1, etc_pkg::CTRL_OFFSET, v, 1'b0);
        repeat (4) @(posedge i_clk);
    endtask

    function automatic logic [31:0] ctrl(input int m1, input int src, input int filt, input int presc,
                                         input int m2, input int pol);
        return {16'h0000, pol[0], m2[0], presc[1:0], filt[3:0], 1'b0, src[2:0], 3'h0, m1[0]};
    endfunction

    // Read monitor: every completed read takes the oldest expected word
    always @(posedge i_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0)
                check(prdata, 32'hdead_beef);
            else
                check(prdata, exp_q.pop_front());
        end
    end

    // Counting-clock pulses, one per active edge; counted off the edge to avoid a race with readers
    always @(negedge i_clk) begin
        if (tick === 1'b1)
            ticks++;
    end

    // Watchdog sized well above the expected run of about 8300 cycles
    initial begin
        repeat (40000) @(posedge i_clk);
        mismatches++;
        complete_run();
    end

    // Main sequence
    initial begin
        logic [31:0] v;
        int n, dv, d, t0, hits;
        i_clk = 1'b0; i_reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000;
        mismatches = 0; checked = 0; ticks = 0;
        v = $urandom(21);
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(etc_pkg::CTRL_OFFSET, 32'h0000_0000, 1'b0);
        rd(etc_pkg::STATUS_OFFSET, 32'h0000_0000, 1'b0);
        rd(12'h008, 32'h0000_0000, 1'b1);
        repeat (4) begin
            v = $urandom;
            v[6:4] = v[14] ? {1'b0, v[5:4]} : v[6:4];
            apb(1'b1, etc_pkg::CTRL_OFFSET, v, 1'b0);
            rd(etc_pkg::CTRL_OFFSET, v & 32'h0000_ff71, 1'b0);
        end
        apb(1'b1, 12'h008, 32'hffff_ffff, 1'b1);
        apb(1'b1, etc_pkg::STATUS_OFFSET, 32'hffff_ffff, 1'b0);
        rd(etc_pkg::CTRL_OFFSET, v & 32'h0000_ff71, 1'b0);
        // Polarity at both pin levels, seen through the status word; clock mode 2 is off
        for (int pol = 0; pol < 2; pol++) begin
            wr_ctrl(ctrl(0, 7, 0, 0, 0, pol));
            for (int lvl = 0; lvl < 2; lvl++) begin
                pm.set_pin(lvl[0]);
                repeat (6) @(posedge i_clk);
                rd(etc_pkg::STATUS_OFFSET, ((lvl ^ pol) != 0) ? 32'h7 : 32'h0, 1'b0);
            end
        end
        pm.set_pin(1'b0);
        // Prescaler ratios counted over 64 pin periods in clock mode 2
        for (int p = 0; p < 4; p++) begin
            wr_ctrl(ctrl(0, 0, 0, p, 1, p % 2));
            fork
                pm.toggle(2, 100);
                begin
                    repeat (80) @(posedge i_clk);
                    t0 = ticks;
                    repeat (256) @(posedge i_clk);
                    check(32'(ticks - t0), 32'(64 >> p));
                end
            join
        end
        // Every filter code: a lasting level passes; for codes other than 0000, a glitch one sample short is dropped
        for (int c = 0; c < 16; c++) begin
            n = n_tab[c];
            dv = div_tab[c];
            wr_ctrl(ctrl(0, 0, c, 0, 1, 0));
            repeat (n * dv + 8) @(posedge i_clk);
            if (n > 1) begin
                hits = 0;
                pm.set_pin(1'b1);
                repeat ((n - 2) * dv) @(posedge i_clk);
                pm.set_pin(1'b0);
                repeat (n * dv + 8) begin
                    @(negedge i_clk);
                    if (ext_filtered === 1'b1)
                        hits++;
                end
                check(32'(hits), 32'h0);
            end
            pm.set_pin(1'b1);
            d = 0;
            while (ext_filtered !== 1'b1 && d < 300) begin
                @(negedge i_clk);
                d++;
            end
            check({31'h0, d >= (n - 1) * dv + 3 && d <= n * dv + 5}, 32'h1);
            if (c == 0)
                check(32'(d), 32'h4);
            pm.set_pin(1'b0);
            repeat (n * dv + 8) @(posedge i_clk);
        end
        // Clock mode 1: only the wired master line, or the selected channel line, counts
        for (int s = 0; s < 7; s++) begin
            wr_ctrl(ctrl(1, s, 0, 0, 0, 0));
            for (int b = 0; b < 8; b++) begin
                t0 = ticks;
                if (s < 4)
                    pm.pulse_master(b, 3);
                else
                    pm.pulse_channel(b % 3, 3);
                repeat (8) @(posedge i_clk);
                check(32'(ticks - t0), ((s < 4) ? (b == map_tab[s]) : (b % 3 == s - 4)) ? 32'h1 : 32'h0);
            end
        end
        // Both clock modes on: the master line is ignored, the pin edge counts
        wr_ctrl(ctrl(1, 0, 0, 0, 1, 0));
        t0 = ticks;
        pm.pulse_master(0, 3);
        repeat (8) @(posedge i_clk);
        pm.set_pin(1'b1);
        repeat (3) @(posedge i_clk);
        pm.set_pin(1'b0);
        repeat (8) @(posedge i_clk);
        check(32'(ticks - t0), 32'h1);
        complete_run();
    end
endmodule // test_timer_ext_trigger_conditioning
`default_nettype wire
